// ===== rtl/acr_pkg.sv
// Package with constants and types for the converter register block.
package acr_pkg;

  localparam int CLK_PERIOD_NS = 8;
  localparam int IDLE_TIMEOUT_MS = 28;
  localparam int IDLE_TIMEOUT_CYCLES =
    (IDLE_TIMEOUT_MS * 1000000) / CLK_PERIOD_NS;
  localparam int CONV_CYCLES_DEF = 64;

  localparam logic [15:0] RESULT_RESET = 16'h0000;
  localparam logic [15:0] CONFIG_RESET = 16'h058B;
  localparam int START_BIT = 15;
  localparam int MODE_BIT = 8;
  localparam int PULLUP_BIT = 3;
  localparam int RSVD_BIT = 0;
  localparam logic [1:0] KEY_VALID = 2'h1;
  localparam logic [3:0] RESULT_RSVD = 4'h0;
  localparam logic [5:0] WORD_BITS = 6'h10;
  localparam logic [5:0] FRAME_BITS = 6'h20;

  typedef struct packed {
    logic start;
    logic [2:0] inputPairSelect;
    logic [2:0] gainRangeSelect;
    logic singleShotMode;
    logic [2:0] sampleRateSelect;
    logic tempSensorSelect;
    logic pullUpEnable;
    logic [1:0] writeValidKey;
    logic reserved;
  } acr_config_t;

  typedef struct packed {
    logic dataOut;
    logic dataOutEn;
    logic pullUpOn;
  } acr_pin_t;

  typedef enum logic [1:0] {
    ACR_IDLE = 2'b00,
    ACR_CONV = 2'b01
  } acr_conv_state_t;

endpackage

// ===== rtl/acr_regs.sv
// Serial register block of a small delta-sigma converter.
//
// Summary of operation
// - Result register is zero after reset until the first conversion ends.
// - Result holds the latest 12-bit two's complement value in bits 15:4.
// - Result bits 3:0 always read zero.
// - Configuration register resets to 058Bh.
// - Start bit starts one conversion only when powered down; reads zero.
// - Bits 14:12 select the input pair.
// - Bits 11:9 select the full-scale range.
// - Bit 8 clear means continuous; set means power-down single-shot.
// - Bits 7:5 select the data rate; code 111 unused.
// - Bit 4 selects the temperature sensor instead of the inputs.
// - Bit 3 enables a weak pull-up on the data pin while deselected.
// - Configuration updates only when the key field bits 2:1 equal 01.
// - Configuration bit 0 ignores writes and reads one.
// - Link clock idles low; change on rising, sample on falling edges.
// - Link clock low for over 28 ms times out the transfer.
// - Chip select high resets the link and releases the data pin.
// - Data pin goes low when a new result is ready.
// - Result shifts out MSB first while the config word is captured.
// - Last two bytes of a 32-bit frame return the configuration after the write; an unkeyed word returns the old one.
`timescale 1ns/10ps
module acr_regs
  import acr_pkg::*;
#(
  parameter int TIMEOUT_CYCLES = IDLE_TIMEOUT_CYCLES,
  parameter int CONV_CYCLES = CONV_CYCLES_DEF
) (
  // System.
  input wire logic clk,
  input wire logic sys_rst,
  // Serial link pins.
  input wire logic chipSelectN,
  input wire logic serialClk,
  input wire logic serialIn,
  output logic dataOutReady,
  output logic dataOutReadyEn,
  output logic dataOutPullUp,
  // Converter core.
  output acr_pkg::acr_config_t activeConfig,
  output logic convStart,
  output logic convBusy,
  input wire logic [11:0] convSample
);
  import acr_pkg::*;

  typedef struct packed {
    logic [1:0] csSync;
    logic [1:0] sckSync;
    logic [1:0] dinSync;
    logic sckPrev;
    logic [5:0] bitCount;
    logic [15:0] shiftOut;
    logic [15:0] shiftIn;
    logic [15:0] echoWord;
    logic [31:0] idleCount;
    logic timedOut;
    logic [15:0] result;
    acr_config_t cfg;
    logic newData;
    acr_conv_state_t convState;
    logic [31:0] convCount;
    logic startPulse;
    logic outBit;
    logic inFrame;
  } acr_state_t;

  acr_state_t stateReg;
  acr_state_t stateNext;

  // Applies the write key and forces fixed bits of a received config word.
  function automatic acr_config_t applyWord(input acr_config_t cur,
                                            input logic [15:0] word);
    acr_config_t nxt;
    nxt = cur;
    if (word[2:1] == KEY_VALID) begin
      nxt = acr_config_t'(word);
      nxt.start = 1'b0;
      nxt.reserved = 1'b1;
    end
    return nxt;
  endfunction

  logic csLow;
  logic sckRise;
  logic sckFall;
  logic [15:0] resultWord;
  logic [15:0] configWord;

  always_comb begin
    csLow = ~stateReg.csSync[1];
    sckRise = stateReg.sckSync[1] & ~stateReg.sckPrev;
    sckFall = ~stateReg.sckSync[1] & stateReg.sckPrev;
    resultWord = {stateReg.result[15:4], RESULT_RSVD};
    configWord = stateReg.cfg;
    configWord[START_BIT] = 1'b0;
    configWord[RSVD_BIT] = 1'b1;
  end

  always_comb begin
    stateNext = stateReg;
    stateNext.csSync = {stateReg.csSync[0], chipSelectN};
    stateNext.sckSync = {stateReg.sckSync[0], serialClk};
    stateNext.dinSync = {stateReg.dinSync[0], serialIn};
    stateNext.sckPrev = stateReg.sckSync[1];
    stateNext.startPulse = 1'b0;

    // Conversion sequencer models the core's busy time.
    case (stateReg.convState)
      ACR_IDLE: begin
        if (!stateReg.cfg.singleShotMode) begin
          stateNext.convState = ACR_CONV;
          stateNext.convCount = '0;
          stateNext.startPulse = 1'b1;
        end
      end
      ACR_CONV: begin
        if (stateReg.convCount == 32'(CONV_CYCLES - 1)) begin
          stateNext.result = {convSample, RESULT_RSVD};
          stateNext.newData = 1'b1;
          stateNext.convState = ACR_IDLE;
          if (!stateReg.cfg.singleShotMode) begin
            stateNext.convCount = '0;
            stateNext.convState = ACR_CONV;
            stateNext.startPulse = 1'b1;
          end
        end else begin
          stateNext.convCount = stateReg.convCount + 32'h1;
        end
      end
      default: stateNext.convState = ACR_IDLE;
    endcase

    if (!csLow) begin
      // Deselected: reset the link and ignore the clock.
      stateNext.bitCount = '0;
      stateNext.inFrame = 1'b0;
      stateNext.timedOut = 1'b0;
      stateNext.idleCount = '0;
    end else begin
      if (stateReg.sckSync[1] || !stateReg.inFrame) begin
        stateNext.idleCount = '0;
      end else if (stateReg.idleCount != 32'(TIMEOUT_CYCLES)) begin
        stateNext.idleCount = stateReg.idleCount + 32'h1;
      end else begin
        stateNext.timedOut = 1'b1;
        stateNext.bitCount = '0;
        stateNext.inFrame = 1'b0;
      end
      if (sckRise) begin
        if (!stateReg.inFrame || stateReg.timedOut) begin
          // First edge locks the result into the shifter.
          stateNext.inFrame = 1'b1;
          stateNext.timedOut = 1'b0;
          stateNext.bitCount = '0;
          stateNext.outBit = resultWord[15];
          stateNext.shiftOut = {resultWord[14:0], 1'b0};
          stateNext.newData = 1'b0;
        end else begin
          stateNext.outBit = stateReg.shiftOut[15];
          stateNext.shiftOut = {stateReg.shiftOut[14:0], 1'b0};
          if (stateReg.bitCount == WORD_BITS) begin
            stateNext.outBit = stateReg.echoWord[15];
            stateNext.shiftOut = {stateReg.echoWord[14:0], 1'b0};
          end
        end
      end
      if (sckFall && stateReg.inFrame && !stateReg.timedOut) begin
        stateNext.shiftIn = {stateReg.shiftIn[14:0], stateReg.dinSync[1]};
        stateNext.bitCount = stateReg.bitCount + 6'h1;
        if (stateReg.bitCount == WORD_BITS - 6'h1) begin
          stateNext.cfg = applyWord(stateReg.cfg,
            {stateReg.shiftIn[14:0], stateReg.dinSync[1]});
          stateNext.echoWord = applyWord(stateReg.cfg,
            {stateReg.shiftIn[14:0], stateReg.dinSync[1]});
          stateNext.echoWord[START_BIT] = 1'b0;
          stateNext.echoWord[RSVD_BIT] = 1'b1;
          // A start request counts only in a keyed word while powered down.
          if (stateReg.shiftIn[14] &&
              stateReg.shiftIn[1:0] == KEY_VALID &&
              stateReg.convState == ACR_IDLE &&
              stateReg.cfg.singleShotMode) begin
            stateNext.startPulse = 1'b1;
            stateNext.convState = ACR_CONV;
            stateNext.convCount = '0;
          end
        end
        if (stateReg.bitCount == FRAME_BITS - 6'h1) begin
          stateNext.bitCount = FRAME_BITS;
        end
      end
    end

    if (sys_rst) begin
      stateNext = '0;
      stateNext.csSync = 2'h3;
      stateNext.dinSync = 2'h0;
      stateNext.result = RESULT_RESET;
      stateNext.cfg = acr_config_t'(CONFIG_RESET);
      stateNext.convState = ACR_IDLE;
      stateNext.outBit = 1'b1;
    end
  end

  always_ff @(posedge clk) begin
    stateReg <= stateNext;
  end

  // Pin drive: ready level before the first edge, shifted data after.
  always_comb begin
    dataOutReadyEn = csLow;
    dataOutReady = stateReg.inFrame ? stateReg.outBit
                                    : ~stateReg.newData;
    dataOutPullUp = ~csLow & stateReg.cfg.pullUpEnable;
    activeConfig = configWord;
    convStart = stateReg.startPulse;
    convBusy = (stateReg.convState == ACR_CONV);
  end

endmodule

// ===== tb/acr_regs_monitor.sv
// Checker for the converter register block ports.
`timescale 1ns/10ps
module acr_regs_monitor
  import acr_pkg::*;
#(
  parameter int TIMEOUT_CYCLES = 200,
  parameter int CONV_CYCLES = 16
) (
  // System.
  input wire logic clk,
  input wire logic sys_rst,
  // Link and converter.
  input wire logic chipSelectN,
  input wire logic serialClk,
  input wire logic serialIn,
  input wire logic dataOutReady,
  input wire logic dataOutReadyEn,
  input wire logic dataOutPullUp,
  input wire acr_pkg::acr_config_t activeConfig,
  input wire logic convStart,
  input wire logic convBusy,
  input wire logic [11:0] convSample
);
  default clocking cb @(posedge clk); endclocking
  default disable iff (sys_rst);
  a_start_reads_zero: assert property (!activeConfig.start)
    else $error("start bit seen set");
  a_rsvd_reads_one: assert property (activeConfig.reserved)
    else $error("reserved bit seen clear");
  a_key_stays_valid: assert property (!$stable(activeConfig) |->
    activeConfig.writeValidKey == KEY_VALID) else $error("bad key stored");
  a_pullup_when_off: assert property (dataOutPullUp |-> !dataOutReadyEn)
    else $error("pull-up while driving");
  a_idle_release: assert property (chipSelectN[*6] |-> !dataOutReadyEn &&
    dataOutPullUp == activeConfig.pullUpEnable) else $error("pin not idle");
  a_start_then_busy: assert property (convStart |-> ##1 convBusy[*8])
    else $error("busy too short");
  a_start_when_idle: assert property (convStart &&
    activeConfig.singleShotMode && $past(activeConfig.singleShotMode)
    |-> !$past(convBusy)) else $error("start while busy");
  a_busy_ends: assert property (convStart |->
    ##[8:40] (!convBusy || convStart)) else $error("conversion hangs");
  cover property (convStart && !activeConfig.singleShotMode);
  cover property (chipSelectN ##1 !chipSelectN);
  cover property (convStart && activeConfig.singleShotMode);
endmodule

// ===== tb/acr_spi_master.sv
// Link master model that runs frames on the serial pins.
`timescale 1ns/10ps
module acr_spi_master (
  // System.
  input wire logic clk,
  // Link pins.
  output logic chipSelectN,
  output logic serialClk,
  output logic serialIn,
  input wire logic dataOutReady,
  input wire logic dataOutReadyEn,
  input wire logic dataOutPullUp
);
  logic pin;
  // A released pin without pull-up shows the inverse of dataOutReady.
  assign pin = dataOutReadyEn ? dataOutReady : dataOutPullUp | ~dataOutReady;
  initial begin
    chipSelectN = 1'b1;
    serialClk = 1'b0;
    serialIn = 1'b0;
  end
  task automatic half();
    repeat (5) @(negedge clk);
  endtask
  task automatic xfer(input int n, input int hold, input logic [31:0] w,
                      output logic rdy, output logic [31:0] r);
    r = '0;
    chipSelectN = 1'b0;
    half();
    rdy = pin;
    for (int i = n - 1; i >= 0; i--) begin
      serialClk = 1'b1;
      serialIn = w[i];
      half();
      serialClk = 1'b0;
      r[i] = pin;
      half();
    end
    serialIn = ~serialIn;
    if (hold > 0) repeat (hold) @(negedge clk);
    else begin
      chipSelectN = 1'b1;
      repeat (2) half();
    end
  endtask
endmodule

// ===== tb/testbench.sv
// Self-checking bench for the converter register block.
`timescale 1ns/10ps
module testbench;
  import acr_pkg::*;
  logic clk, sys_rst, chipSelectN, serialClk, serialIn, rdy;
  logic dataOutReady, dataOutReadyEn, dataOutPullUp, convStart, convBusy;
  logic [11:0] convSample;
  logic [31:0] rd;
  acr_config_t activeConfig;
  int badCount, checkCount;
  acr_regs #(.TIMEOUT_CYCLES(200), .CONV_CYCLES(16)) i_acr_regs (
    .clk(clk), .sys_rst(sys_rst), .chipSelectN(chipSelectN),
    .serialClk(serialClk), .serialIn(serialIn), .dataOutReady(dataOutReady),
    .dataOutReadyEn(dataOutReadyEn), .dataOutPullUp(dataOutPullUp),
    .activeConfig(activeConfig), .convStart(convStart),
    .convBusy(convBusy), .convSample(convSample));
  acr_spi_master i_acr_spi_master (.clk(clk), .chipSelectN(chipSelectN),
    .serialClk(serialClk), .serialIn(serialIn), .dataOutReady(dataOutReady),
    .dataOutReadyEn(dataOutReadyEn), .dataOutPullUp(dataOutPullUp));
  task automatic chk(input string n, input logic [15:0] e, g);
    checkCount++;
    if (g !== e) begin
      badCount++;
      $display("CHECK FAILED %s expected %h seen %h", n, e, g);
    end
  endtask
  task automatic xf(input int n, input logic [15:0] w, input int hold = 0);
    i_acr_spi_master.xfer(n, hold, {w, w}, rdy, rd);
  endtask
  task automatic reportAndStop();
    $display("checks %0d mismatches %0d", checkCount, badCount);
    if (badCount == 0 && checkCount > 0) $display("Finished cleanly");
    else $display("Finished with errors");
    $finish;
  endtask
  initial begin
    clk = 1'b0;
    forever #4 clk = ~clk;
  end
  initial begin
    repeat (20000) @(posedge clk);
    badCount++;
    reportAndStop();
  end
  initial begin
    sys_rst = 1'b1;
    convSample = 12'hA5C;
    repeat (12) @(negedge clk);
    sys_rst = 1'b0;
    repeat (4) @(negedge clk);
    xf(32, 16'h0000);
    chk("ready", 16'h1, {15'h0, rdy});
    chk("result", 16'h0000, rd[31:16]);
    chk("echo", 16'h058B, rd[15:0]);
    xf(16, 16'h858A);
    repeat (40) @(negedge clk);
    xf(32, 16'h7BD2);
    chk("ready", 16'h0, {15'h0, rdy});
    chk("result", 16'hA5C0, rd[31:16]);
    chk("echo", 16'h7BD3, rd[15:0]);
    chk("config", 16'h7BD3, activeConfig);
    chk("pullup", 16'h0, {15'h0, dataOutPullUp});
    for (int k = 0; k < 4; k++) if (k != 1) begin
      xf(16, {13'h02C0, k[1:0], 1'b0});
      chk("ready", 16'h1, {15'h0, rdy});
      chk("result", 16'hA5C0, rd[15:0]);
      chk("config", 16'h7BD3, activeConfig);
    end
    convSample = 12'h800;
    xf(16, 16'h048A);
    repeat (40) @(negedge clk);
    xf(16, 16'h058A);
    chk("ready", 16'h0, {15'h0, rdy});
    chk("result", 16'h8000, rd[15:0]);
    chk("pullup", 16'h1, {15'h0, dataOutPullUp});
    xf(8, 16'hFFFF, 300);
    xf(16, 16'h4F8A);
    chk("config", 16'h4F8B, activeConfig);
    reportAndStop();
  end
endmodule
bind acr_regs acr_regs_monitor #(.TIMEOUT_CYCLES(TIMEOUT_CYCLES),
  .CONV_CYCLES(CONV_CYCLES)) i_acr_regs_monitor (.clk(clk),
  .sys_rst(sys_rst), .chipSelectN(chipSelectN), .serialClk(serialClk),
  .serialIn(serialIn), .dataOutReady(dataOutReady),
  .dataOutReadyEn(dataOutReadyEn), .dataOutPullUp(dataOutPullUp),
  .activeConfig(activeConfig), .convStart(convStart),
  .convBusy(convBusy), .convSample(convSample));
